// [logic/cbr_regs.vh]
// Constants of the bus-release handshake: states, widths and machine-cycle timing.
`ifndef CBR_REGS_VH
`define CBR_REGS_VH

// Arbiter states, binary coded.
`define CBR_ST_RUN 1'h0
`define CBR_ST_GRANT 1'h1

// Clock cycles in one machine cycle.
`define CBR_MCYC_CLKS 2

// Bus widths.
`define CBR_MEM_AW 16
`define CBR_IO_AW 16
`define CBR_DW 8

// Reset values of the transaction outputs.
`define CBR_ADDR_RST 16'h0000
`define CBR_DATA_RST 8'h00

`endif

// [logic/cbr_mcycle.v]
// Machine-cycle phase counter of the bus-release handshake.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.vh"

module cbr_mcycle #(
	parameter integer MCYC_CLKS = `CBR_MCYC_CLKS
) (
	// Clock and resets.
	input wire clk_sys,
	input wire rst,
	input wire clear_n,
	// Control.
	input wire run,
	// Phase outputs.
	output reg mc_first,
	output reg mc_last
);

	// Width of the phase counter, wide enough for any sensible count.
	localparam integer CW = (MCYC_CLKS > 2) ? $clog2(MCYC_CLKS) : 1;
	// Last phase as a full integer, cut to the counter width on purpose.
	localparam integer LAST_I = MCYC_CLKS - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];
	localparam [CW-1:0] ZERO = {CW{1'b0}};
	localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

	// Current phase within the machine cycle.
	reg [CW-1:0] phase;
	// Phase that the counter takes at the next edge.
	reg [CW-1:0] next_phase;

	// The counter restarts whenever the core is stopped, so a resumed
	// core always begins with a whole machine cycle.
	always @* begin
		next_phase = ZERO;
		if (run && phase != LAST) begin
			next_phase = phase + ONE;
		end
	end

	// While run stays high, every machine cycle lasts exactly the same number of clocks.
	always @(posedge clk_sys or negedge clear_n) begin
		if (!clear_n) begin
			phase <= ZERO;
			mc_first <= 1'b1;
			mc_last <= 1'b0;
		end else if (rst) begin
			phase <= ZERO;
			mc_first <= 1'b1;
			mc_last <= 1'b0;
		end else begin
			phase <= next_phase;
			mc_first <= (next_phase == ZERO);
			mc_last <= (next_phase == LAST);
		end
	end

endmodule // cbr_mcycle

`default_nettype wire

// [logic/cbr_bus_release.v]
// Bus-release handshake of the processor core: grant, output hold and interrupt gating.
// How it works
// - Sample inputs, change outputs on rising clock.
// - Master clear asynchronously initialises every flip-flop.
// - Grant output shows the core has stopped.
// - Markers, addresses and data held low during grant.
// - Halt and sleep indicators stay during grant.
// - No interrupt sampling while grant is active.
// - Release bus only at instruction boundary.
// - Machine cycle is always two clocks.
// - Fully synchronous, static, no three-state buses.
// - Memory address reads all zeros during grant.
// - Stall ignored during grant, halt or sleep.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.vh"

module cbr_bus_release #(
	parameter integer MCYC_CLKS = `CBR_MCYC_CLKS,
	parameter integer MEM_AW = `CBR_MEM_AW,
	parameter integer IO_AW = `CBR_IO_AW,
	parameter integer DW = `CBR_DW
) (
	// Clock and resets.
	input wire clk_sys,
	input wire rst,
	input wire clear_n,
	// Other bus master.
	input wire bus_req,
	output reg bus_grant,
	// External requests.
	input wire stall_req,
	input wire int_req,
	input wire nmi_req,
	// Core sequencer status.
	input wire core_inst_end,
	input wire core_halt,
	input wire core_sleep,
	input wire core_nmi_taken,
	// Core transaction markers and buses before the hold.
	input wire core_iack,
	input wire core_nmiack,
	input wire core_reti,
	input wire core_first,
	input wire core_mem_tran,
	input wire core_io_tran,
	input wire [MEM_AW-1:0] core_mem_addr,
	input wire [DW-1:0] core_mem_data,
	input wire [IO_AW-1:0] core_io_addr,
	input wire [DW-1:0] core_io_data,
	// Control back to the core.
	output reg core_run,
	output wire mc_first,
	output wire mc_last,
	output reg int_to_core,
	output reg nmi_to_core,
	// State indicators.
	output reg halt_state,
	output reg sleep_state,
	output reg stall_eff,
	// Transaction outputs after the hold.
	output reg iack_tran,
	output reg nmiack_tran,
	output reg reti_tran,
	output reg first_cycle_marker,
	output reg mem_tran,
	output reg io_tran,
	output reg [MEM_AW-1:0] mem_addr_out,
	output reg [DW-1:0] mem_data_out,
	output reg [IO_AW-1:0] io_addr_out,
	output reg [DW-1:0] io_data_out
);

	// Arbiter state.
	reg state;
	// State after the next edge.
	reg next_state;
	// Grant value after the next edge.
	reg next_grant;
	// Stall as honoured after the next edge.
	reg next_stall;
	// Latched non-maskable request awaiting the core.
	reg nmi_pend;
	// Boundary at which the bus may be handed over.
	wire at_boundary;

	// Stalls are honoured only while the core actually runs.
	function stall_ok;
		input stall;
		input grant;
		input halt;
		input sleep;
		begin
			stall_ok = stall & ~grant & ~halt & ~sleep;
		end
	endfunction

	// Machine-cycle phase counter; it runs only while the core runs.
	cbr_mcycle #(
		.MCYC_CLKS(MCYC_CLKS)
	) u_mcycle (
		.clk_sys(clk_sys),
		.rst(rst),
		.clear_n(clear_n),
		.run(core_run),
		.mc_first(mc_first),
		.mc_last(mc_last)
	);

	// The bus is only given up at the end of the last machine cycle of an
	// instruction, or while the core sits frozen in halt or sleep, which
	// is itself an instruction boundary.
	assign at_boundary = (mc_last & core_inst_end & core_run) | core_halt | core_sleep;

	// Arbiter next state. The request is the other master's to raise and
	// hold; the core only reacts to it.
	always @* begin
		next_state = state;
		case (state)
			`CBR_ST_RUN: begin
				if (bus_req && at_boundary && !stall_eff) begin
					next_state = `CBR_ST_GRANT;
				end
			end
			`CBR_ST_GRANT: begin
				if (!bus_req) begin
					next_state = `CBR_ST_RUN;
				end
			end
			default: begin
				next_state = `CBR_ST_RUN;
			end
		endcase
		next_grant = (next_state == `CBR_ST_GRANT);
		next_stall = stall_ok(stall_req, next_grant, core_halt, core_sleep);
	end

	// Arbiter, grant and core run enable. The user reset returns the state
	// machine to running; master clear does the same asynchronously.
	always @(posedge clk_sys or negedge clear_n) begin
		if (!clear_n) begin
			state <= `CBR_ST_RUN;
			bus_grant <= 1'b0;
			core_run <= 1'b0;
			stall_eff <= 1'b0;
		end else if (rst) begin
			state <= `CBR_ST_RUN;
			bus_grant <= 1'b0;
			core_run <= 1'b0;
			stall_eff <= 1'b0;
		end else begin
			state <= next_state;
			bus_grant <= next_grant;
			// A frozen core resumes with the next instruction once the
			// grant is gone.
			core_run <= ~next_grant & ~next_stall & ~core_halt & ~core_sleep;
			stall_eff <= next_stall;
		end
	end

	// Halt and sleep indicators simply follow the core; the grant has no
	// say over them, so both may stand together.
	always @(posedge clk_sys or negedge clear_n) begin
		if (!clear_n) begin
			halt_state <= 1'b0;
			sleep_state <= 1'b0;
		end else if (rst) begin
			halt_state <= 1'b0;
			sleep_state <= 1'b0;
		end else begin
			halt_state <= core_halt;
			sleep_state <= core_sleep;
		end
	end

	// Interrupt sampling. Requests are not looked at while the bus is
	// granted, so a halted or sleeping core only wakes after release.
	// The maskable request is not latched, so the requester must hold it.
	always @(posedge clk_sys or negedge clear_n) begin
		if (!clear_n) begin
			nmi_pend <= 1'b0;
			int_to_core <= 1'b0;
			nmi_to_core <= 1'b0;
		end else if (rst) begin
			nmi_pend <= 1'b0;
			int_to_core <= 1'b0;
			nmi_to_core <= 1'b0;
		end else begin
			// A new request in the same cycle as the core taking the old
			// one wins, so no edge is lost.
			if (nmi_req && !bus_grant) begin
				nmi_pend <= 1'b1;
			end else if (core_nmi_taken) begin
				nmi_pend <= 1'b0;
			end
			int_to_core <= int_req & ~bus_grant & ~next_grant;
			nmi_to_core <= nmi_pend & ~bus_grant & ~next_grant;
		end
	end

	// Transaction markers, registered so every output changes on the
	// rising edge only, and forced low for the whole grant.
	always @(posedge clk_sys or negedge clear_n) begin
		if (!clear_n) begin
			iack_tran <= 1'b0;
			nmiack_tran <= 1'b0;
			reti_tran <= 1'b0;
			first_cycle_marker <= 1'b0;
			mem_tran <= 1'b0;
			io_tran <= 1'b0;
		end else if (rst) begin
			iack_tran <= 1'b0;
			nmiack_tran <= 1'b0;
			reti_tran <= 1'b0;
			first_cycle_marker <= 1'b0;
			mem_tran <= 1'b0;
			io_tran <= 1'b0;
		end else begin
			iack_tran <= core_iack & ~next_grant;
			nmiack_tran <= core_nmiack & ~next_grant;
			reti_tran <= core_reti & ~next_grant;
			first_cycle_marker <= core_first & ~next_grant;
			mem_tran <= core_mem_tran & ~next_grant;
			io_tran <= core_io_tran & ~next_grant;
		end
	end

	// Address and data outputs. These are data registers that the user
	// reset leaves alone, so only master clear initialises them. All are
	// driven actively at every time; there is no released, floating bus,
	// which is why the other master needs its own multiplexer.
	always @(posedge clk_sys or negedge clear_n) begin
		if (!clear_n) begin
			mem_addr_out <= {MEM_AW{1'b0}};
			mem_data_out <= {DW{1'b0}};
			io_addr_out <= {IO_AW{1'b0}};
			io_data_out <= {DW{1'b0}};
		end else if (next_grant) begin
			mem_addr_out <= {MEM_AW{1'b0}};
			mem_data_out <= {DW{1'b0}};
			io_addr_out <= {IO_AW{1'b0}};
			io_data_out <= {DW{1'b0}};
		end else begin
			// The memory address bus tracks the core; the data buses and the I/O address keep their value
			// between transactions to save switching power.
			mem_addr_out <= core_mem_addr;
			if (core_mem_tran) begin
				mem_data_out <= core_mem_data;
			end
			if (core_io_tran) begin
				io_addr_out <= core_io_addr;
				io_data_out <= core_io_data;
			end
		end
	end

endmodule // cbr_bus_release

`default_nettype wire

// [bench/cbr_bus_release_monitor.sv]
// Checker of the bus-release handshake, watching the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module cbr_bus_release_monitor #(parameter integer MEM_AW = 16) (
	// Clock, resets and handshake.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clear_n,
	input wire logic bus_req,
	input wire logic bus_grant,
	input wire logic core_run,
	// Core status and phase.
	input wire logic core_halt,
	input wire logic core_sleep,
	input wire logic core_inst_end,
	input wire logic mc_first,
	input wire logic mc_last,
	// Gated outputs.
	input wire logic int_to_core,
	input wire logic halt_state,
	input wire logic stall_eff,
	input wire logic mem_tran,
	input wire logic iack_tran,
	input wire logic first_cycle_marker,
	input wire logic [MEM_AW-1:0] mem_addr_out
);
	// Either reset forces the grant and markers, so both mask every check.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst || !clear_n);
	property p_hold; bus_grant |-> !(mem_tran | iack_tran | first_cycle_marker); endproperty
	a_hold: assert property (p_hold) else $error("marker under grant");
	property p_zero; bus_grant |-> mem_addr_out == '0; endproperty
	a_zero: assert property (p_zero) else $error("address under grant");
	property p_halt; bus_grant && $past(core_halt) |-> halt_state; endproperty
	a_halt: assert property (p_halt) else $error("halt lost");
	property p_int; bus_grant |-> !int_to_core; endproperty
	a_int: assert property (p_int) else $error("interrupt under grant");
	property p_stall; bus_grant && $past(bus_grant) |-> !stall_eff; endproperty
	a_stall: assert property (p_stall) else $error("stall under grant");
	// A new grant must follow a request seen at an instruction boundary or in halt or sleep.
	property p_take; $rose(bus_grant) |-> $past(bus_req) && !core_run &&
		($past(mc_last) && $past(core_inst_end) && $past(core_run) ||
		$past(core_halt) || $past(core_sleep)); endproperty
	a_take: assert property (p_take) else $error("grant off boundary");
	property p_keep; bus_grant && bus_req |=> bus_grant; endproperty
	a_keep: assert property (p_keep) else $error("grant dropped");
	property p_drop; bus_grant && !bus_req |=> !bus_grant; endproperty
	a_drop: assert property (p_drop) else $error("grant held");
	property p_mcyc; mc_first && core_run |=> mc_last && !mc_first; endproperty
	a_mcyc: assert property (p_mcyc) else $error("machine cycle length");
	// The phase always wraps from the last clock back to the first one.
	property p_mwrap; mc_last |=> mc_first && !mc_last; endproperty
	a_mwrap: assert property (p_mwrap) else $error("machine cycle wrap");
	c_take: cover property ($rose(bus_grant));
	c_halt: cover property (bus_grant && halt_state);
	c_drop: cover property ($fell(bus_grant));
endmodule // cbr_bus_release_monitor
`default_nettype wire

// [bench/cbr_dma_model.sv]
// Second bus master that borrows the bus for a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module cbr_dma_model (
	// Clock, reset and grant.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic bus_grant,
	// Bench controls.
	input wire logic want,
	input wire logic [3:0] hold,
	// Request to the core.
	output var logic bus_req
);
	logic [3:0] used; // Cycles spent on the bus.
	// The request stands until the bus was used hold plus one cycles; a slow hold stretches the grant.
	always @(posedge clk_sys) begin
		if (rst) begin
			bus_req <= 1'h0;
			used <= 4'h0;
		end else if (!bus_req) begin
			bus_req <= want;
			used <= 4'h0;
		end else if (bus_grant) begin
			used <= used + 4'h1;
			if (used == hold) bus_req <= 1'h0;
		end
	end
endmodule // cbr_dma_model
`default_nettype wire

// [bench/test_cbr_bus_release.sv]
// Self-checking bench of the bus-release handshake.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %s expected %h seen %h", n, e, a); end end
module test_cbr_bus_release;
	logic clk_sys, rst, clear_n, stall_req, int_req, core_inst_end, core_halt, core_sleep, want;
	logic nmi_req, nmi_taken; // Non-maskable request and its acceptance by the core.
	logic [5:0] mk; // Raw transaction markers from the core.
	logic [15:0] addr; // Raw address, also feeding the data buses.
	wire logic bus_req, bus_grant, core_run, int_to_core, halt_state, sleep_state, stall_eff;
	wire logic mem_tran, iack_tran, first_cycle_marker, nmiack_tran, reti_tran;
	wire logic io_tran, nmi_to_core;
	wire logic [15:0] mem_addr_out, io_addr_out;
	wire logic [7:0] mem_data_out, io_data_out;
	int miscompares = 0;
	int num_checks = 0;
	cbr_bus_release i_dut (.clk_sys, .rst, .clear_n, .bus_req, .bus_grant, .stall_req,
		.int_req, .nmi_req, .core_inst_end, .core_halt, .core_sleep,
		.core_nmi_taken(nmi_taken), .core_iack(mk[5]), .core_nmiack(mk[4]), .core_reti(mk[3]),
		.core_first(mk[2]), .core_mem_tran(mk[1]), .core_io_tran(mk[0]),
		.core_mem_addr(addr), .core_mem_data(addr[7:0]), .core_io_addr(addr),
		.core_io_data(addr[15:8]), .core_run, .mc_first(), .mc_last(), .int_to_core,
		.nmi_to_core, .halt_state, .sleep_state, .stall_eff, .iack_tran, .nmiack_tran,
		.reti_tran, .first_cycle_marker, .mem_tran, .io_tran, .mem_addr_out,
		.mem_data_out, .io_addr_out, .io_data_out);
	cbr_dma_model i_dma (.clk_sys, .rst, .bus_grant, .want, .hold(4'h3), .bus_req);
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Bounded wait for the grant to reach v; running out ends the run.
	task automatic wait_grant(input logic v);
		int n;
		n = 0;
		while (bus_grant !== v && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("grant wait", v, bus_grant)
		if (bus_grant !== v) final_report();
	endtask
	// Request mid-instruction, then at the boundary; outputs must be held while granted.
	task automatic t_boundary;
		core_inst_end = 1'h0;
		mk = 6'h3F;
		addr = 16'hA5A5;
		int_req = 1'h1;
		want = 1'h1;
		repeat (8) @(negedge clk_sys);
		`CHK("grant", 1'h0, bus_grant)
		`CHK("addr", 16'hA5A5, mem_addr_out)
		`CHK("int", 1'h1, int_to_core)
		core_inst_end = 1'h1;
		wait_grant(1'h1);
		want = 1'h0;
		`CHK("mem_tran", 1'h0, mem_tran)
		`CHK("iack", 1'h0, iack_tran)
		`CHK("first", 1'h0, first_cycle_marker)
		`CHK("addr", 16'h0000, mem_addr_out)
		`CHK("int", 1'h0, int_to_core)
		`CHK("run", 1'h0, core_run)
		`CHK("marks", 3'h0, {nmiack_tran, reti_tran, io_tran})
		`CHK("buses", 32'h00000000, {mem_data_out, io_addr_out, io_data_out})
		wait_grant(1'h0);
		`CHK("mem_tran", 1'h1, mem_tran)
		`CHK("addr", 16'hA5A5, mem_addr_out)
		`CHK("run", 1'h1, core_run)
		`CHK("marks", 3'h7, {nmiack_tran, reti_tran, io_tran})
		`CHK("buses", 32'hA5A5A5A5, {mem_data_out, io_addr_out, io_data_out})
		$display("boundary test done");
	endtask
	// Grant in halt (s=0) or sleep (s=1) with a stall pending, which must be ignored.
	task automatic t_state(input int s);
		core_inst_end = 1'h0;
		core_halt = s == 0;
		core_sleep = s == 1;
		stall_req = 1'h1;
		want = 1'h1;
		wait_grant(1'h1);
		want = 1'h0;
		// A short non-maskable pulse under the grant must be lost.
		nmi_req = 1'h1;
		@(negedge clk_sys);
		nmi_req = 1'h0;
		`CHK("halt", s == 0, halt_state)
		`CHK("sleep", s == 1, sleep_state)
		`CHK("stall", 1'h0, stall_eff)
		`CHK("int", 1'h0, int_to_core)
		wait_grant(1'h0);
		core_halt = 1'h0;
		core_sleep = 1'h0;
		repeat (2) @(negedge clk_sys);
		`CHK("stall", 1'h1, stall_eff)
		`CHK("int", 1'h1, int_to_core)
		`CHK("nmi", 1'h0, nmi_to_core)
		stall_req = 1'h0;
		// The same pulse outside the grant is latched and passed on.
		nmi_req = 1'h1;
		@(negedge clk_sys);
		nmi_req = 1'h0;
		@(negedge clk_sys);
		`CHK("nmi", 1'h1, nmi_to_core)
		nmi_taken = 1'h1;
		@(negedge clk_sys);
		nmi_taken = 1'h0;
		$display("state test %0d done", s);
	endtask
	// Master clear works without a clock edge and clears the held address.
	task automatic t_clear;
		clear_n = 1'h0;
		#5;
		`CHK("addr", 16'h0000, mem_addr_out)
		$display("clear test done");
	endtask
	initial begin
		rst = 1'h1;
		clear_n = 1'h0;
		stall_req = 1'h0;
		int_req = 1'h0;
		nmi_req = 1'h0;
		nmi_taken = 1'h0;
		core_inst_end = 1'h0;
		core_halt = 1'h0;
		core_sleep = 1'h0;
		want = 1'h0;
		mk = 6'h00;
		addr = 16'h0000;
		@(negedge clk_sys);
		clear_n = 1'h1;
		repeat (5) @(negedge clk_sys);
		rst = 1'h0;
		t_boundary();
		t_state(0);
		t_state(1);
		t_clear();
		final_report();
	end
endmodule // test_cbr_bus_release
bind cbr_bus_release cbr_bus_release_monitor #(.MEM_AW(MEM_AW)) i_mon (.clk_sys, .rst,
	.clear_n, .bus_req, .bus_grant, .core_run, .core_halt, .core_sleep, .core_inst_end,
	.mc_first, .mc_last, .int_to_core, .halt_state, .stall_eff, .mem_tran, .iack_tran,
	.first_cycle_marker, .mem_addr_out);
`default_nettype wire
